/* File: pdma_pkg.sv */
// package for the peripheral dma channel block: register map, fields,
// reset values, engine states and the memory bus carrier structs.
// assumes a 32-bit apb register port and a simple valid/ready memory bus.
package pdma_pkg;

    ////////////////////////////////////////////////////////////////////////
    // channel window and register offsets (byte addresses within a window)
    localparam int unsigned CH_WIN_LSB     = 6;
    localparam logic [5:0]  OFF_MEM_PTR    = 6'h00;
    localparam logic [5:0]  OFF_PER_SEL    = 6'h04;
    localparam logic [5:0]  OFF_XFER_CNT   = 6'h08;
    localparam logic [5:0]  OFF_PTR_RELOAD = 6'h0c;
    localparam logic [5:0]  OFF_CNT_RELOAD = 6'h10;
    localparam logic [5:0]  OFF_CTRL       = 6'h14;
    localparam logic [5:0]  OFF_MODE       = 6'h18;
    localparam logic [5:0]  OFF_STATUS     = 6'h1c;
    localparam logic [5:0]  OFF_IRQ_SET    = 6'h20;
    localparam logic [5:0]  OFF_IRQ_CLR    = 6'h24;
    localparam logic [5:0]  OFF_IRQ_MASK   = 6'h28;
    localparam logic [5:0]  OFF_IRQ_STAT   = 6'h2c;

    ////////////////////////////////////////////////////////////////////////
    // field positions and widths
    localparam int unsigned CTRL_ON_BIT    = 0;
    localparam int unsigned CTRL_OFF_BIT   = 1;
    localparam int unsigned CTRL_ERROR_CLEAR_BIT  = 8;
    localparam int unsigned STAT_ON_BIT    = 0;
    localparam int unsigned IRQ_RCZ_BIT    = 0;
    localparam int unsigned IRQ_TRC_BIT    = 1;
    localparam int unsigned IRQ_TRANSFER_ERROR_FLAG_BIT   = 2;
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned SIZE_W         = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0]      RST_PTR   = 32'h0000_0000;
    localparam logic [CNT_W-1:0] RST_CNT   = 16'h0000;
    localparam logic [SIZE_W-1:0] RST_SIZE = 2'h0;
    localparam logic [IRQ_W-1:0] RST_MASK  = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // transfer size codes
    localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h0;
    localparam logic [SIZE_W-1:0] SIZE_HALF = 2'h1;
    localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;

    // peripheral holding registers: base plus identifier shifted left by stride bits
    localparam logic [31:0] PER_HOLD_BASE   = 32'hffff_0000;
    localparam int unsigned PER_HOLD_STRIDE = 10;

    ////////////////////////////////////////////////////////////////////////
    // engine states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } pdma_state_e;

    // memory bus request, held until ready
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [SIZE_W-1:0] size;
        logic [31:0]       addr;
        logic [31:0]       wdata;
    } pdma_mem_req_s;

    // memory bus answer
    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } pdma_mem_rsp_s;

endpackage

/* File: pdma_top.sv */
// peripheral dma channels: apb register file, fixed-priority arbiter and
// a single memory bus master moving one item per grant.
// assumes peripherals sit on pclk and hold their request until acknowledged;
// peripheral holding registers are reached over the same memory bus.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps

// Functional notes
// - control write: bit0 one starts channel, bit1 one stops it; zeros ignored
// - irq set/clear writes set/clear mask bits; mask register reads them back
// - reload-counter-zero status is high whenever reload count is zero
// - transfer-finished status high when active and reload counts both zero
// - failed memory access for a channel raises its transfer error flag
// - simultaneous requests: lowest-numbered channel wins, channel 0 highest
// - on access error set error flag and halt only that channel
// - control bit8 one clears error flag, channel may transfer again
// - each channel owns a 64-byte window at n times 0x40
// - pointer holds buffer start, then always the next address accessed
// - identifier selects handshake line, direction and holding register address
// - 16-bit count readable anytime, shows items still to move
// - count zero with nonzero reload count: pointer takes reload pointer
// - count zero with positive reload count: count takes reload count
// - count zero and reload count zero: channel moves nothing more
// - reload count register clears whenever the count is reloaded
// - size field: 00 byte, 01 half-word, 10 word, 11 reserved
// - pointer advances by 1, 2 or 4 per item according to size
// - count drops by one per item regardless of size
// - peripheral requests, controller acknowledges once the item starts
module pdma_top
#(
    parameter int unsigned NCH    = 4,
    parameter int unsigned NPER   = 8,
    parameter int unsigned PID_W  = 3,
    parameter int unsigned APB_AW = 12,
    parameter logic [NPER-1:0] TX_MASK = 8'h0f
)
(
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [APB_AW-1:0]      paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // peripheral handshakes
    input  wire logic [NPER-1:0]        hs_req,
    output logic      [NPER-1:0]        hs_ack,
    // memory bus master
    output pdma_pkg::pdma_mem_req_s     mem_req,
    input  wire pdma_pkg::pdma_mem_rsp_s mem_rsp
);
    import pdma_pkg::*;

    localparam int unsigned CH_IW = APB_AW - CH_WIN_LSB;
    if (NCH < 1 || NCH > (1 << CH_IW))
        $error("pdma_top: NCH does not fit the apb address space");
    if (NPER < 1 || NPER > (1 << PID_W) || PID_W > 32)
        $error("pdma_top: NPER or PID_W out of range");

    ////////////////////////////////////////////////////////////////////////
    // per-channel state
    logic [31:0]       mem_ptr_ff    [NCH];
    logic [PID_W-1:0]  per_id_ff     [NCH];
    logic [CNT_W-1:0]  xfer_cnt_ff   [NCH];
    logic [31:0]       ptr_reload_ff [NCH];
    logic [CNT_W-1:0]  cnt_reload_ff [NCH];
    logic [SIZE_W-1:0] size_ff       [NCH];
    logic [IRQ_W-1:0]  irq_mask_ff   [NCH];
    logic [NCH-1:0]    on_ff;
    logic [NCH-1:0]    err_ff;
    logic [NCH-1:0]    cand;
    // engine
    pdma_state_e             state_ff;
    logic [$clog2(NCH+1)-1:0] cur_ff;
    logic [31:0]             dst_addr_ff;
    pdma_mem_req_s           req_ff;
    logic [NPER-1:0]         ack_ff;
    // apb
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic              acc_phase;
    logic              wr_en;
    logic [CH_IW-1:0]  ch_idx;
    logic [5:0]        reg_off;
    logic              ch_ok;
    logic              off_ok;
    assign acc_phase = psel && penable && !pready_ff;
    assign wr_en     = psel && penable && pready_ff && pwrite && ch_ok && off_ok;
    assign ch_idx    = paddr[APB_AW-1:CH_WIN_LSB];
    assign reg_off   = paddr[CH_WIN_LSB-1:0];
    assign ch_ok     = 32'(ch_idx) < NCH;
    assign off_ok    = (reg_off[1:0] == 2'h0) && (reg_off <= OFF_IRQ_STAT);

    ////////////////////////////////////////////////////////////////////////
    // engine handshakes with the memory bus
    logic acc_done;
    logic acc_fail;
    logic item_ok;
    assign acc_done = req_ff.valid && mem_rsp.ready;
    assign acc_fail = acc_done && mem_rsp.err;
    assign item_ok  = (state_ff == ST_WRITE) && acc_done && !mem_rsp.err;

    ////////////////////////////////////////////////////////////////////////
    // per-channel registers
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gen_ch
            logic sel;
            logic mine;
            logic reload;
            logic [31:0] step;
            assign sel    = wr_en && (32'(ch_idx) == g);
            assign mine   = (32'(cur_ff) == g);
            assign reload = (xfer_cnt_ff[g] == '0) && (cnt_reload_ff[g] != '0);
            assign step   = (size_ff[g] == SIZE_BYTE) ? 32'h1 :
                            (size_ff[g] == SIZE_HALF) ? 32'h2 : 32'h4;
            assign cand[g] = on_ff[g] && !err_ff[g] && (xfer_cnt_ff[g] != '0)
                             && (32'(per_id_ff[g]) < NPER)
                             && hs_req[32'(per_id_ff[g]) % NPER];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mem_ptr_ff[g] <= RST_PTR;
                else if (sel && reg_off == OFF_MEM_PTR)
                    mem_ptr_ff[g] <= pwdata;
                else if (item_ok && mine)
                    mem_ptr_ff[g] <= mem_ptr_ff[g] + step;
                else if (reload)
                    mem_ptr_ff[g] <= ptr_reload_ff[g];
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    xfer_cnt_ff[g] <= RST_CNT;
                else if (sel && reg_off == OFF_XFER_CNT)
                    xfer_cnt_ff[g] <= pwdata[CNT_W-1:0];
                else if (item_ok && mine)
                    xfer_cnt_ff[g] <= xfer_cnt_ff[g] - 16'h1;
                else if (reload)
                    xfer_cnt_ff[g] <= cnt_reload_ff[g];
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cnt_reload_ff[g] <= RST_CNT;
                else if (sel && reg_off == OFF_CNT_RELOAD)
                    cnt_reload_ff[g] <= pwdata[CNT_W-1:0];
                else if (reload && !(sel && reg_off == OFF_XFER_CNT))
                    cnt_reload_ff[g] <= RST_CNT;
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    per_id_ff[g]     <= '0;
                    ptr_reload_ff[g] <= RST_PTR;
                    size_ff[g]       <= RST_SIZE;
                end
                else if (sel)
                begin
                    if (reg_off == OFF_PER_SEL)
                        per_id_ff[g] <= pwdata[PID_W-1:0];
                    if (reg_off == OFF_PTR_RELOAD)
                        ptr_reload_ff[g] <= pwdata;
                    if (reg_off == OFF_MODE)
                        size_ff[g] <= pwdata[SIZE_W-1:0];
                end
            end
            // disable wins over enable in the same write
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    on_ff[g] <= 1'b0;
                else if (sel && reg_off == OFF_CTRL && pwdata[CTRL_OFF_BIT])
                    on_ff[g] <= 1'b0;
                else if (sel && reg_off == OFF_CTRL && pwdata[CTRL_ON_BIT])
                    on_ff[g] <= 1'b1;
            end
            // hardware error set wins over a clear in the same cycle
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    err_ff[g] <= 1'b0;
                else if (acc_fail && mine && state_ff != ST_IDLE)
                    err_ff[g] <= 1'b1;
                else if (sel && reg_off == OFF_CTRL && pwdata[CTRL_ERROR_CLEAR_BIT])
                    err_ff[g] <= 1'b0;
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    irq_mask_ff[g] <= RST_MASK;
                else if (sel && reg_off == OFF_IRQ_SET)
                    irq_mask_ff[g] <= irq_mask_ff[g] | pwdata[IRQ_W-1:0];
                else if (sel && reg_off == OFF_IRQ_CLR)
                    irq_mask_ff[g] <= irq_mask_ff[g] & ~pwdata[IRQ_W-1:0];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // fixed priority: lowest channel number wins
    logic                     any_cand;
    logic [$clog2(NCH+1)-1:0] win;
    always_comb
    begin
        any_cand = 1'b0;
        win      = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (cand[i])
            begin
                any_cand = 1'b1;
                win      = ($clog2(NCH+1))'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine: read source, write destination, one item per grant
    logic [PID_W-1:0] win_pid;
    logic [31:0]      win_hold;
    logic             win_tx;
    logic [SIZE_W-1:0] win_size;
    assign win_pid  = per_id_ff[32'(win) % NCH];
    assign win_hold = PER_HOLD_BASE + (32'(win_pid) << PER_HOLD_STRIDE);
    assign win_tx   = TX_MASK[32'(win_pid) % NPER];
    assign win_size = (size_ff[32'(win) % NCH] == SIZE_BYTE) ? SIZE_BYTE :
                      (size_ff[32'(win) % NCH] == SIZE_HALF) ? SIZE_HALF : SIZE_WORD;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff    <= ST_IDLE;
            cur_ff      <= '0;
            dst_addr_ff <= '0;
            req_ff      <= '0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (any_cand)
                    begin
                        cur_ff       <= win;
                        req_ff.valid <= 1'b1;
                        req_ff.write <= 1'b0;
                        req_ff.size  <= win_size;
                        req_ff.wdata <= '0;
                        req_ff.addr  <= win_tx ? mem_ptr_ff[32'(win) % NCH] : win_hold;
                        dst_addr_ff  <= win_tx ? win_hold : mem_ptr_ff[32'(win) % NCH];
                        state_ff     <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (acc_fail)
                    begin
                        req_ff.valid <= 1'b0;
                        state_ff     <= ST_IDLE;
                    end
                    else if (acc_done)
                    begin
                        req_ff.write <= 1'b1;
                        req_ff.addr  <= dst_addr_ff;
                        req_ff.wdata <= mem_rsp.rdata;
                        state_ff     <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (acc_done)
                    begin
                        req_ff.valid <= 1'b0;
                        req_ff.write <= 1'b0;
                        state_ff     <= ST_IDLE;
                    end
                end
                default:
                begin
                    req_ff.valid <= 1'b0;
                    state_ff     <= ST_IDLE;
                end
            endcase
        end
    end

    // one-cycle acknowledge on the granted handshake line as the item starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ack_ff <= '0;
        else
        begin
            ack_ff <= '0;
            if (state_ff == ST_IDLE && any_cand)
                ack_ff[32'(win_pid) % NPER] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: one wait state, read data and error registered
    logic [31:0] rd_val;
    logic [CH_IW-1:0] rc;
    always_comb
    begin
        rc     = ch_ok ? ch_idx : '0;
        rd_val = '0;
        case (reg_off)
            OFF_MEM_PTR:    rd_val = mem_ptr_ff[32'(rc) % NCH];
            OFF_PER_SEL:    rd_val = 32'(per_id_ff[32'(rc) % NCH]);
            OFF_XFER_CNT:   rd_val = 32'(xfer_cnt_ff[32'(rc) % NCH]);
            OFF_PTR_RELOAD: rd_val = ptr_reload_ff[32'(rc) % NCH];
            OFF_CNT_RELOAD: rd_val = 32'(cnt_reload_ff[32'(rc) % NCH]);
            OFF_MODE:       rd_val = 32'(size_ff[32'(rc) % NCH]);
            OFF_STATUS:     rd_val[STAT_ON_BIT] = on_ff[32'(rc) % NCH];
            OFF_IRQ_MASK:   rd_val = 32'(irq_mask_ff[32'(rc) % NCH]);
            OFF_IRQ_STAT:
            begin
                rd_val[IRQ_RCZ_BIT]  = (cnt_reload_ff[32'(rc) % NCH] == '0);
                rd_val[IRQ_TRC_BIT]  = (cnt_reload_ff[32'(rc) % NCH] == '0)
                                       && (xfer_cnt_ff[32'(rc) % NCH] == '0);
                rd_val[IRQ_TRANSFER_ERROR_FLAG_BIT] = err_ff[32'(rc) % NCH];
            end
            default:        rd_val = '0;
        endcase
        if (!ch_ok || !off_ok)
            rd_val = '0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else
        begin
            pready_ff  <= acc_phase;
            pslverr_ff <= acc_phase && !(ch_ok && off_ok);
            prdata_ff  <= (acc_phase && !pwrite) ? rd_val : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign hs_ack  = ack_ff;
    assign mem_req = req_ff;

endmodule

/* File: pdma_monitor.sv */
// assertion checker for pdma_top, bound to every instance of it.
// sees only the top ports; one pclk domain with async active-low reset.
`timescale 1ns/10ps
module pdma_monitor
#(
    parameter int unsigned     NCH     = 4,
    parameter int unsigned     NPER    = 8,
    parameter int unsigned     PID_W   = 3,
    parameter int unsigned     APB_AW  = 12,
    parameter logic [NPER-1:0] TX_MASK = 8'h0f
)
(
    // clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // apb slave side
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [APB_AW-1:0]       paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // handshakes and memory bus
    input wire logic [NPER-1:0]         hs_req,
    input wire logic [NPER-1:0]         hs_ack,
    input wire pdma_pkg::pdma_mem_req_s mem_req,
    input wire pdma_pkg::pdma_mem_rsp_s mem_rsp
);
    import pdma_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    ack_single_a: assert property ($onehot0(hs_ack))
        else $error("more than one ack at once");
    ack_starts_a: assert property (|hs_ack |-> mem_req.valid && !mem_req.write)
        else $error("ack without a starting read");
    ack_cause_a: assert property (|hs_ack |-> (hs_ack & $past(hs_req)) == hs_ack)
        else $error("ack on a line that did not request");
    ack_pulse_a: assert property (|hs_ack |=> hs_ack == '0)
        else $error("ack longer than one cycle");
    req_hold_a: assert property (mem_req.valid && !mem_rsp.ready |=> $stable(mem_req))
        else $error("memory request changed before ready");
    size_legal_a: assert property (mem_req.valid |-> mem_req.size != 2'h3)
        else $error("reserved size on the bus");
    read_write_a: assert property (mem_req.valid && !mem_req.write && mem_rsp.ready
        && !mem_rsp.err |=> mem_req.valid && mem_req.write)
        else $error("read not followed by write");
    err_abandon_a: assert property (mem_req.valid && mem_rsp.ready && mem_rsp.err
        |=> !mem_req.valid)
        else $error("item not abandoned after bus error");
    map_error_a: assert property (psel && penable && pready
        && paddr[APB_AW-1:6] >= NCH |-> pslverr)
        else $error("unmapped channel without slave error");
    cover property (|hs_ack);
    cover property (mem_req.valid && mem_rsp.ready && mem_rsp.err);
    cover property (psel && penable && pready && pslverr);
endmodule

bind pdma_top pdma_monitor #(.NCH(NCH), .NPER(NPER), .PID_W(PID_W), .APB_AW(APB_AW),
    .TX_MASK(TX_MASK)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hs_req, .hs_ack, .mem_req, .mem_rsp);

/* File: pdma_mem_model.sv */
// memory bus slave model: random wait of 0..3 cycles, one-cycle ready.
// addresses with top nibble d fail, as an invalid location would.
`timescale 1ns/10ps
module pdma_mem_model
(
    // clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // memory bus slave
    input wire pdma_pkg::pdma_mem_req_s mem_req,
    output pdma_pkg::pdma_mem_rsp_s     mem_rsp
);
    import pdma_pkg::*;
    logic [7:0] lfsr_ff;
    logic [1:0] wait_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lfsr_ff <= 8'h5a;
            wait_ff <= 2'h0;
            mem_rsp <= '0;
        end
        else
        begin
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            mem_rsp.ready <= 1'b0;
            mem_rsp.err <= 1'b0;
            // data lines move while idle
            mem_rsp.rdata <= {4{lfsr_ff}};
            if (mem_req.valid && !mem_rsp.ready && wait_ff != 2'h0)
                wait_ff <= wait_ff - 2'h1;
            else if (mem_req.valid && !mem_rsp.ready)
            begin
                mem_rsp.ready <= 1'b1;
                mem_rsp.err <= mem_req.addr[31:28] == 4'hd;
                mem_rsp.rdata <= ~mem_req.addr;
                wait_ff <= lfsr_ff[1:0];
            end
        end
    end
endmodule

/* File: test_peripheral_dma_channels.sv */
// self-checking bench: apb master, peripheral request lines and a
// scoreboard of expected memory writes; memory is pdma_mem_model.
`timescale 1ns/10ps
module test_peripheral_dma_channels;
    import pdma_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = 12'h0;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [7:0]    hs_req = 8'h0;
    logic [7:0]    hs_ack;
    pdma_mem_req_s mem_req;
    pdma_mem_rsp_s mem_rsp;
    int            pend [8] = '{default: 0};
    logic [33:0]   exp_q [$];
    logic [31:0]   seed = 32'hff79;
    logic [31:0]   p0, p1, q0, v0, rd, src;
    logic          er;
    int            err_total = 0;
    int            compares = 0;
    int            cyc = 0;

    pdma_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hs_req, .hs_ack, .mem_req, .mem_rsp);
    pdma_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_rsp);

    initial forever #50 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [33:0] hold(input logic [1:0] sz, input int peripheral_identifier);
        return {sz, PER_HOLD_BASE + (32'(peripheral_identifier) << PER_HOLD_STRIDE)};
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [2:0] ch, input logic [5:0] off,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {3'h0, ch, off};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rc(input logic [2:0] ch, input logic [5:0] off, input logic [31:0] exp);
        apb(1'b0, ch, off, 32'h0);
        chk("read data", rd, exp);
        chk("read error", {31'h0, er}, 32'h0);
    endtask

    task automatic cfg(input logic [2:0] ch, input logic [31:0] peripheral_identifier, input logic [31:0] ptr,
        input logic [31:0] cnt, input logic [31:0] sz);
        apb(1'b1, ch, OFF_MEM_PTR, ptr);
        apb(1'b1, ch, OFF_PER_SEL, peripheral_identifier);
        apb(1'b1, ch, OFF_XFER_CNT, cnt);
        apb(1'b1, ch, OFF_MODE, sz);
        apb(1'b1, ch, OFF_CTRL, 32'h1);
    endtask

    task automatic drain();
        do @(posedge pclk); while (exp_q.size() != 0 || mem_req.valid !== 1'b0);
        repeat (3) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // peripherals drop their request for a cycle after each ack
    always @(posedge pclk)
        for (int p = 0; p < 8; p++)
        begin
            if (hs_ack[p] === 1'b1)
                pend[p] <= pend[p] - 1;
            hs_req[p] <= pend[p] != 0 && hs_ack[p] !== 1'b1;
        end

    always @(posedge pclk)
        if (mem_req.valid === 1'b1 && mem_req.write === 1'b1 && mem_rsp.ready === 1'b1)
        begin
            chk("write expected", 32'(exp_q.size() != 0), 32'h1);
            if (exp_q.size() != 0)
            begin
                chk("write address", mem_req.addr, exp_q[0][31:0]);
                chk("write data", mem_req.wdata, ~src);
                chk("write size", {30'h0, mem_req.size}, {30'h0, exp_q[0][33:32]});
                void'(exp_q.pop_front());
            end
        end
        else if (mem_rsp.ready === 1'b1)
            src = mem_req.addr;

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int o = 0; o < 48; o += 4)
            rc(3'h0, 6'(o), (o == 44) ? 32'h3 : 32'h0);
        apb(1'b0, 3'h4, OFF_MEM_PTR, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        apb(1'b1, 3'h0, OFF_IRQ_SET, 32'h5);
        rc(3'h0, OFF_IRQ_MASK, 32'h5);
        apb(1'b1, 3'h0, OFF_IRQ_CLR, 32'h1);
        rc(3'h0, OFF_IRQ_MASK, 32'h4);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, 3'h3, OFF_MODE, 32'(s));
            rc(3'h3, OFF_MODE, 32'(s));
        end
        p0 = rnd() & 32'h0fff_fff0;
        p1 = rnd() & 32'h0fff_fff0;
        q0 = rnd() & 32'h0fff_ffff;
        v0 = rnd() & 32'h0fff_fff0;
        cfg(3'h1, 32'h5, p0, 32'h2, 32'h2);
        cfg(3'h2, 32'h1, q0, 32'h1, 32'h0);
        apb(1'b1, 3'h2, OFF_PTR_RELOAD, p1);
        apb(1'b1, 3'h2, OFF_CNT_RELOAD, 32'h1);
        exp_q = '{{2'h2, p0}, {2'h2, p0 + 32'h4}, hold(2'h0, 1), hold(2'h0, 1)};
        pend[5] <= 2;
        pend[1] <= 2;
        drain();
        rc(3'h1, OFF_MEM_PTR, p0 + 32'h8);
        rc(3'h1, OFF_XFER_CNT, 32'h0);
        rc(3'h2, OFF_MEM_PTR, p1 + 32'h1);
        rc(3'h2, OFF_CNT_RELOAD, 32'h0);
        rc(3'h2, OFF_IRQ_STAT, 32'h3);
        apb(1'b1, 3'h1, OFF_CTRL, 32'h0);
        rc(3'h1, OFF_STATUS, 32'h1);
        apb(1'b1, 3'h1, OFF_CTRL, 32'h2);
        rc(3'h1, OFF_STATUS, 32'h0);
        cfg(3'h3, 32'h3, p0, 32'h1, 32'h1);
        cfg(3'h0, 32'h2, 32'hd000_0000, 32'h2, 32'h2);
        exp_q.push_back(hold(2'h1, 3));
        pend[2] <= 1;
        pend[3] <= 1;
        drain();
        rc(3'h0, OFF_IRQ_STAT, 32'h5);
        rc(3'h0, OFF_MEM_PTR, 32'hd000_0000);
        rc(3'h0, OFF_XFER_CNT, 32'h2);
        rc(3'h3, OFF_MEM_PTR, p0 + 32'h2);
        apb(1'b1, 3'h0, OFF_MEM_PTR, v0);
        apb(1'b1, 3'h0, OFF_CTRL, 32'h100);
        exp_q = '{hold(2'h2, 2), hold(2'h2, 2)};
        pend[2] <= 2;
        drain();
        rc(3'h0, OFF_IRQ_STAT, 32'h3);
        rc(3'h0, OFF_MEM_PTR, v0 + 32'h8);
        tally_and_finish();
    end
endmodule
